// ### rtl/pll_seq_pkg.sv
// Shared constants and types for the PLL mode and reset sequencer
package pll_seq_pkg;
  // APB register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BW_OFS = 8'h04;
  localparam logic [7:0] SEL_OFS = 8'h08;
  localparam logic [7:0] XPT_OFS = 8'h0C;
  localparam logic [7:0] DIV_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS = 8'h14;
  localparam logic [7:0] NVM_OFS = 8'h18;
  // Control bit positions
  localparam int CTRL_HARD_BIT = 0;
  localparam int CTRL_SOFT_BIT = 1;
  localparam int CTRL_FAST_BIT = 2;
  localparam int CTRL_STORE_BIT = 3;
  // Bandwidth code field layout and limits
  localparam int BW_W = 6;
  localparam int NBW_LSB = 0;
  localparam int FBW_LSB = 8;
  localparam logic [5:0] NBW_MIN = 6'h00;  // 0.1 Hz
  localparam logic [5:0] NBW_MAX = 6'h24;  // 4 kHz
  localparam logic [5:0] FBW_MIN = 6'h14;  // 100 Hz
  localparam logic [5:0] FBW_MAX = 6'h24;  // 4 kHz
  // Store layout: word address of each saved register
  localparam int NVM_AW = 3;
  localparam logic [2:0] NVM_BW_ADR = 3'h0;
  localparam logic [2:0] NVM_SEL_ADR = 3'h1;
  localparam logic [2:0] NVM_XPT_ADR = 3'h2;
  localparam logic [2:0] NVM_DIV_ADR = 3'h3;
  localparam logic [2:0] NVM_LAST_ADR = 3'h3;
  localparam logic [31:0] UNMAPPED_RDATA = 32'h0000_0000;
  // Two-bit mode code as seen by software
  localparam logic [1:0] MODE_FREE = 2'h0;
  localparam logic [1:0] MODE_ACQ = 2'h1;
  localparam logic [1:0] MODE_LOCK = 2'h2;
  localparam logic [1:0] MODE_HOLD = 2'h3;
  typedef enum logic [2:0] {
    ST_INIT, ST_LOAD, ST_FREE, ST_ACQ, ST_LOCK, ST_HOLD
  } seq_state_t;
endpackage

// ### rtl/config_nonvolatile_store.sv
// Small word memory standing in for the configuration non-volatile store
`timescale 1ns/10ps
`default_nettype none
module config_nonvolatile_store #(
  parameter int AW = 3,
  parameter int DW = 32
) (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [AW-1:0] i_addr,
  input wire logic [DW-1:0] i_wdata,
  output logic [DW-1:0] o_rdata
);
  // Starts empty; only the clocked write below changes it
  logic [DW-1:0] mem [0:(1<<AW)-1] = '{default: '0};

  // Content survives reset; a write reads back the old word, registered read
  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule
`default_nettype wire

// ### rtl/pll_mode_reset_sequencer.sv
// PLL mode and reset sequencer with APB control registers
`timescale 1ns/10ps
`default_nettype none
module pll_mode_reset_sequencer
  import pll_seq_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 10,
  parameter int N_DIV = 5
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hard_reset_n_pin,
  input wire logic [N_IN-1:0] i_in_valid,
  input wire logic i_pll_locked,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_init_done,
  output logic [1:0] o_mode,
  output logic [N_OUT-1:0] o_out_clk_en,
  output logic [BW_W-1:0] o_loop_bw,
  output logic [1:0] o_in_sel,
  output logic [N_OUT*3-1:0] o_xpt_sel,
  output logic [31:0] o_div_cfg,
  output logic o_soft_apply
);
  // ----------------------------------------
  // Hard reset sources
  // ----------------------------------------
  logic pin_q_r;
  logic hard_req;
  logic ctrl_hard_r;
  assign hard_req = !pin_q_r || ctrl_hard_r;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_q_r <= 1'b1;
    end else begin
      pin_q_r <= i_hard_reset_n_pin;
    end
  end

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  seq_state_t state_r, state_nxt;
  logic [NVM_AW-1:0] ld_adr_r;
  logic ld_wait_r;
  logic [31:0] nvm_rdata;
  logic ready_st;
  logic [1:0] auto_sel;
  logic [1:0] sel_in;
  logic sel_valid;
  logic any_valid;
  logic man_mode_r;
  logic [1:0] man_sel_r;
  logic [1:0] act_sel_r;

  assign ready_st = (state_r != ST_INIT) && (state_r != ST_LOAD);
  assign any_valid = |i_in_valid;

  // Lowest-numbered valid input wins in automatic selection
  function automatic logic [1:0] first_valid(input logic [N_IN-1:0] v);
    first_valid = 2'h0;
    for (int k = N_IN - 1; k >= 0; k--) begin
      if (v[k]) begin
        first_valid = k[1:0];
      end
    end
  endfunction

  assign auto_sel = first_valid(i_in_valid);
  assign sel_in = man_mode_r ? man_sel_r : auto_sel;
  assign sel_valid = i_in_valid[sel_in];

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_INIT: state_nxt = ST_LOAD;
      ST_LOAD: begin
        if (!ld_wait_r && ld_adr_r == NVM_LAST_ADR) begin
          state_nxt = ST_FREE;
        end
      end
      ST_FREE: begin
        if (sel_valid) begin
          state_nxt = ST_ACQ;
        end
      end
      ST_ACQ: begin
        if (!sel_valid) begin
          state_nxt = ST_FREE;
        end else if (i_pll_locked) begin
          state_nxt = ST_LOCK;
        end
      end
      ST_LOCK: begin
        if (!sel_valid) begin
          state_nxt = any_valid && !man_mode_r ? ST_ACQ : ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (sel_valid) begin
          state_nxt = ST_ACQ;
        end
      end
      default: state_nxt = ST_INIT;
    endcase
  end

  // Any hard reset reruns the whole power-up path
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_INIT;
    end else if (hard_req) begin
      state_r <= ST_INIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Configuration load from store
  // ----------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ld_adr_r <= NVM_BW_ADR;
      ld_wait_r <= 1'b1;
    end else if (state_r != ST_LOAD) begin
      ld_adr_r <= NVM_BW_ADR;
      ld_wait_r <= 1'b1;
    end else if (ld_wait_r) begin
      ld_wait_r <= 1'b0;
    end else if (ld_adr_r != NVM_LAST_ADR) begin
      ld_adr_r <= ld_adr_r + 3'h1;
      ld_wait_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic acc;
  logic wr_acc;
  logic loading;
  logic [31:0] bw_r, sel_r, xpt_r, div_r;
  logic fast_en_r;
  logic store_req_r;
  logic [NVM_AW-1:0] store_adr_r;
  logic nvm_we;
  logic [NVM_AW-1:0] nvm_adr;
  logic [31:0] nvm_wdata;
  logic [31:0] rd_mux;
  logic mapped;

  assign acc = i_psel && i_penable && ready_st;
  assign wr_acc = acc && i_pwrite;
  assign loading = (state_r == ST_LOAD) && !ld_wait_r;
  assign mapped = (i_paddr == CTRL_OFS) || (i_paddr == BW_OFS) || (i_paddr == SEL_OFS)
    || (i_paddr == XPT_OFS) || (i_paddr == DIV_OFS) || (i_paddr == STAT_OFS)
    || (i_paddr == NVM_OFS);

  // Out-of-range bandwidth codes clamp into the selectable range
  function automatic logic [BW_W-1:0] clamp_bw(input logic [BW_W-1:0] v,
      input logic [BW_W-1:0] lo, input logic [BW_W-1:0] hi);
    clamp_bw = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  always_comb begin
    case (i_paddr)
      CTRL_OFS: rd_mux = {28'h0, store_req_r, fast_en_r, 1'b0, ctrl_hard_r};
      BW_OFS: rd_mux = bw_r;
      SEL_OFS: rd_mux = sel_r;
      XPT_OFS: rd_mux = xpt_r;
      DIV_OFS: rd_mux = div_r;
      STAT_OFS: rd_mux = {27'h0, i_pll_locked, act_sel_r, o_mode};
      default: rd_mux = UNMAPPED_RDATA;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= i_psel && !o_pready && ready_st && !hard_req;
      o_prdata <= rd_mux;
      o_pslverr <= i_psel && !o_pready && !mapped;
    end
  end

  // Register file: cleared on hard reset, then filled by the load sequence
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      bw_r <= 32'h0000_0000;
      sel_r <= 32'h0000_0000;
      xpt_r <= 32'h0000_0000;
      div_r <= 32'h0000_0000;
      fast_en_r <= 1'b0;
      ctrl_hard_r <= 1'b0;
    end else if (state_r == ST_INIT) begin
      bw_r <= 32'h0000_0000;
      sel_r <= 32'h0000_0000;
      xpt_r <= 32'h0000_0000;
      div_r <= 32'h0000_0000;
      fast_en_r <= 1'b0;
      ctrl_hard_r <= 1'b0;
    end else if (loading) begin
      case (ld_adr_r)
        NVM_BW_ADR: bw_r <= nvm_rdata;
        NVM_SEL_ADR: sel_r <= nvm_rdata;
        NVM_XPT_ADR: xpt_r <= nvm_rdata;
        default: div_r <= nvm_rdata;
      endcase
    end else if (wr_acc && o_pready) begin
      case (i_paddr)
        CTRL_OFS: begin
          ctrl_hard_r <= i_pwdata[CTRL_HARD_BIT];
          fast_en_r <= i_pwdata[CTRL_FAST_BIT];
        end
        BW_OFS: bw_r <= i_pwdata;
        SEL_OFS: sel_r <= i_pwdata;
        XPT_OFS: xpt_r <= i_pwdata;
        DIV_OFS: div_r <= i_pwdata;
        default: ;
      endcase
    end
  end

  // Store write: all four registers per request, one per cycle, starting at the bandwidth word
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      store_req_r <= 1'b0;
      store_adr_r <= NVM_BW_ADR;
    end else if (!ready_st) begin
      store_req_r <= 1'b0;
      store_adr_r <= NVM_BW_ADR;
    end else if (wr_acc && o_pready && i_paddr == CTRL_OFS && i_pwdata[CTRL_STORE_BIT]) begin
      store_req_r <= 1'b1;
      store_adr_r <= NVM_BW_ADR;
    end else if (store_req_r) begin
      store_adr_r <= store_adr_r + 3'h1;
      store_req_r <= store_adr_r != NVM_LAST_ADR;
    end
  end

  assign nvm_we = store_req_r;
  assign nvm_adr = store_req_r ? store_adr_r : ld_adr_r;
  assign nvm_wdata = (store_adr_r == NVM_BW_ADR) ? bw_r :
    (store_adr_r == NVM_SEL_ADR) ? sel_r :
    (store_adr_r == NVM_XPT_ADR) ? xpt_r : div_r;

  config_nonvolatile_store #(
    .AW(NVM_AW),
    .DW(32)
  ) u_store (
    .i_core_clk(i_core_clk),
    .i_we(nvm_we),
    .i_addr(nvm_adr),
    .i_wdata(nvm_wdata),
    .o_rdata(nvm_rdata)
  );

  // ----------------------------------------
  // Soft reset: apply staged settings, no reload
  // ----------------------------------------
  logic soft_wr;
  logic apply;
  assign soft_wr = wr_acc && o_pready && i_paddr == CTRL_OFS && i_pwdata[CTRL_SOFT_BIT];
  assign apply = soft_wr || (state_r == ST_LOAD && state_nxt == ST_FREE);

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      man_mode_r <= 1'b0;
      man_sel_r <= 2'h0;
      o_div_cfg <= 32'h0000_0000;
      o_xpt_sel <= '0;
      o_soft_apply <= 1'b0;
    end else begin
      o_soft_apply <= soft_wr;
      if (apply) begin
        man_mode_r <= sel_r[2];
        man_sel_r <= sel_r[1:0];
        // Last loaded word arrives at the same edge as the load end
        o_div_cfg <= loading ? nvm_rdata : div_r;
        o_xpt_sel <= xpt_r[N_OUT*3-1:0];
      end
    end
  end

  // ----------------------------------------
  // Outputs toward the analog loop
  // ----------------------------------------
  logic [BW_W-1:0] nbw, fbw;
  logic [1:0] mode_nxt;
  assign nbw = clamp_bw(bw_r[NBW_LSB +: BW_W], NBW_MIN, NBW_MAX);
  assign fbw = clamp_bw(bw_r[FBW_LSB +: BW_W], FBW_MIN, FBW_MAX);
  assign mode_nxt = (state_nxt == ST_ACQ) ? MODE_ACQ :
    (state_nxt == ST_LOCK) ? MODE_LOCK :
    (state_nxt == ST_HOLD) ? MODE_HOLD : MODE_FREE;

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_mode <= MODE_FREE;
      o_init_done <= 1'b0;
      o_out_clk_en <= '0;
      o_loop_bw <= NBW_MIN;
      o_in_sel <= 2'h0;
      act_sel_r <= 2'h0;
    end else if (hard_req || state_nxt == ST_INIT || state_nxt == ST_LOAD) begin
      o_mode <= MODE_FREE;
      o_init_done <= 1'b0;
      o_out_clk_en <= '0;
      o_loop_bw <= NBW_MIN;
      o_in_sel <= 2'h0;
      act_sel_r <= 2'h0;
    end else begin
      o_mode <= mode_nxt;
      o_init_done <= 1'b1;
      o_out_clk_en <= {N_OUT{1'b1}};
      o_loop_bw <= (fast_en_r && state_nxt == ST_ACQ) ? fbw : nbw;
      o_in_sel <= sel_in;
      act_sel_r <= sel_in;
    end
  end
endmodule
`default_nettype wire

// ### bench/apb_host_model.sv
// APB host stand-in that runs one transfer per go request
`timescale 1ns/10ps
`default_nettype none
module apb_host_model (
  input wire logic i_core_clk,
  input wire logic i_go,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_pready,
  input wire logic [31:0] i_prdata,
  input wire logic i_pslverr,
  output logic o_psel = 1'b0,
  output logic o_penable = 1'b0,
  output logic o_pwrite = 1'b0,
  output logic [7:0] o_paddr = 8'h00,
  output logic [31:0] o_pwdata = 32'h0000_0000,
  output logic o_done = 1'b0,
  output logic [31:0] o_rdata = 32'h0000_0000,
  output logic o_err = 1'b0
);
  always @(posedge i_core_clk) begin
    o_done <= 1'b0;
    if (o_psel && o_penable && i_pready) begin
      o_rdata <= i_prdata;
      o_err <= i_pslverr;
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      // Stale data is not left on the bus
      o_pwdata <= ~o_pwdata;
      o_done <= 1'b1;
    end else if (o_psel) begin
      o_penable <= 1'b1;
    end else if (i_go) begin
      o_psel <= 1'b1;
      o_pwrite <= i_wr;
      o_paddr <= i_addr;
      o_pwdata <= i_wdata;
    end
  end
endmodule
`default_nettype wire

// ### bench/pll_seq_props.sv
// Port assertions for the PLL mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module pll_seq_props
  import pll_seq_pkg::*;
#(
  parameter int N_IN = 4,
  parameter int N_OUT = 10
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hard_reset_n_pin,
  input wire logic [N_IN-1:0] i_in_valid,
  input wire logic o_pready,
  input wire logic o_init_done,
  input wire logic [1:0] o_mode,
  input wire logic [N_OUT-1:0] o_out_clk_en
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_clk_off_init: assert property (!o_init_done |-> o_out_clk_en == '0)
    else $error("clock on in init");
  a_mode_init: assert property (!o_init_done |-> o_mode == MODE_FREE)
    else $error("mode set in init");
  a_ready_init: assert property (!o_init_done |-> !o_pready)
    else $error("ready in init");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready two cycles");
  a_pin_hard: assert property ($fell(i_hard_reset_n_pin) |-> ##[1:3] !o_init_done)
    else $error("pin did not reset");
  a_free_first: assert property ($rose(o_init_done) |-> o_mode == MODE_FREE)
    else $error("not free after init");
  a_acq_start: assert property (
    o_init_done && o_mode == MODE_FREE && i_in_valid != '0
    |-> ##[1:2] (o_mode == MODE_ACQ || !o_init_done))
    else $error("no acquisition");
  a_hold_enter: assert property (
    o_mode == MODE_LOCK && i_in_valid == '0 |-> ##[1:2] (o_mode == MODE_HOLD || !o_init_done))
    else $error("no holdover");
  a_hold_exit: assert property (
    o_mode == MODE_HOLD && i_in_valid != '0 |-> ##[1:2] (o_mode == MODE_ACQ || !o_init_done))
    else $error("holdover kept");
endmodule
bind pll_mode_reset_sequencer pll_seq_props #(.N_IN(N_IN), .N_OUT(N_OUT)) i_pll_seq_props (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_hard_reset_n_pin(i_hard_reset_n_pin),
  .i_in_valid(i_in_valid), .o_pready(o_pready), .o_init_done(o_init_done),
  .o_mode(o_mode), .o_out_clk_en(o_out_clk_en));
`default_nettype wire

// ### bench/test_pll_mode_reset_sequencer.sv
// Self-checking testbench for the PLL mode and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module test_pll_mode_reset_sequencer
  import pll_seq_pkg::*;
();
  logic clk, rst, pin_n, lck, go, wr, pready, pslverr, idone, done, er, psel, pen, pwr, sapl;
  logic [3:0] vld;
  logic [7:0] adr, padr;
  logic [31:0] wd, pwd, prd, div, rd;
  logic [1:0] mode, isel;
  logic [9:0] cen;
  logic [5:0] bw;
  logic [29:0] xpt;
  int err_total, samples_checked;
  always #10 clk = ~clk;
  pll_mode_reset_sequencer i_pll_mode_reset_sequencer (
    .i_core_clk(clk), .i_rst(rst), .i_hard_reset_n_pin(pin_n), .i_in_valid(vld),
    .i_pll_locked(lck), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
    .i_pwdata(pwd), .o_prdata(prd), .o_pready(pready), .o_pslverr(pslverr),
    .o_init_done(idone), .o_mode(mode), .o_out_clk_en(cen), .o_loop_bw(bw),
    .o_in_sel(isel), .o_xpt_sel(xpt), .o_div_cfg(div), .o_soft_apply(sapl));
  apb_host_model i_apb_host_model (
    .i_core_clk(clk), .i_go(go), .i_wr(wr), .i_addr(adr), .i_wdata(wd), .i_pready(pready),
    .i_prdata(prd), .i_pslverr(pslverr), .o_psel(psel), .o_penable(pen), .o_pwrite(pwr),
    .o_paddr(padr), .o_pwdata(pwd), .o_done(done), .o_rdata(rd), .o_err(er));
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    go <= 1'b1;
    wr <= w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    go <= 1'b0;
    while (done !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk("apb_done", 1, done);
    if (done !== 1'b1) close_out();
  endtask
  task automatic wait_init();
    int n = 0;
    while (idone !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk("init_done", 1, idone);
    if (idone !== 1'b1) close_out();
  endtask
  task automatic wmode(input logic [1:0] m);
    int n = 0;
    while (mode !== m && n < 10) begin
      @(negedge clk);
      n++;
    end
    chk("mode", m, mode);
    if (mode !== m) close_out();
    @(negedge clk);
  endtask
  task automatic t_init();
    @(negedge clk);
    chk("init_low", 0, idone);
    chk("clk_off", 0, cen);
    wait_init();
    chk("free", MODE_FREE, mode);
    chk("clk_on", 1, |cen);
    $display("t_init done");
  endtask
  task automatic t_regs();
    apb(1'b1, BW_OFS, 32'h0000_013F);
    @(negedge clk);
    chk("bw_clamp", NBW_MAX, bw);
    apb(1'b1, BW_OFS, 32'h0000_2005);
    apb(1'b0, BW_OFS, '0);
    chk("bw_rd", 32'h0000_2005, rd);
    apb(1'b0, 8'h40, '0);
    chk("unmap_err", 1, er);
    chk("unmap_rd", UNMAPPED_RDATA, rd);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    apb(1'b1, CTRL_OFS, 32'h0000_0004);
    @(posedge clk);
    vld <= 4'h1;
    wmode(MODE_ACQ);
    chk("bw_fast", 6'h20, bw);
    @(posedge clk);
    lck <= 1'b1;
    wmode(MODE_LOCK);
    chk("bw_norm", 6'h05, bw);
    @(posedge clk);
    vld <= 4'h0;
    lck <= 1'b0;
    wmode(MODE_HOLD);
    @(posedge clk);
    vld <= 4'h4;
    wmode(MODE_ACQ);
    chk("auto_sel", 2'h2, isel);
    $display("t_modes done");
  endtask
  task automatic t_soft();
    apb(1'b1, DIV_OFS, 32'h1234_5678);
    apb(1'b1, XPT_OFS, 32'h0000_0004);
    apb(1'b1, SEL_OFS, 32'h0000_0006);
    chk("div_held", 0, div);
    apb(1'b1, CTRL_OFS, 32'h0000_0006);
    chk("soft_pulse", 1, sapl);
    @(posedge clk);
    vld <= 4'h5;
    repeat (2) @(negedge clk);
    chk("soft_once", 0, sapl);
    chk("man_sel", 2'h2, isel);
    chk("div_new", 32'h1234_5678, div);
    chk("xpt_new", 30'h4, xpt);
    chk("no_reload", 1, idone);
    $display("t_soft done");
  endtask
  task automatic t_hard();
    int n = 0;
    apb(1'b1, CTRL_OFS, 32'h0000_0008);
    while (n < 20) begin
      apb(1'b0, CTRL_OFS, '0);
      if (rd[CTRL_STORE_BIT] === 1'b0) break;
      n++;
    end
    chk("store_idle", 0, rd[CTRL_STORE_BIT]);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (4) @(negedge clk);
    chk("pin_init", 0, idone);
    chk("pin_clk", 0, cen);
    @(posedge clk);
    pin_n <= 1'b1;
    wait_init();
    chk("div_reload", 32'h1234_5678, div);
    apb(1'b0, CTRL_OFS, '0);
    chk("ctrl_clr", 0, rd);
    apb(1'b1, CTRL_OFS, 32'h0000_0001);
    repeat (3) @(negedge clk);
    chk("bit_init", 0, idone);
    wait_init();
    chk("xpt_reload", 30'h4, xpt);
    $display("t_hard done");
  endtask
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pin_n = 1'b1;
    vld = 4'h0;
    lck = 1'b0;
    go = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0000_0000;
    err_total = 0;
    samples_checked = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_init();
    t_regs();
    t_modes();
    t_soft();
    t_hard();
    close_out();
  end
endmodule
`default_nettype wire
